// File: hw/qhbp_host.sv
// Host controller driving a quad UART parallel bus port in either bus style
`timescale 1ns/10ps
module qhbp_host
  import qhbp_pkg::*;
(
  input wire logic mclk_i,                     // System clock, 250 MHz
  input wire logic rst_i,                      // Synchronous reset, active high
  input wire logic bus_style_i,                // 1 strobe mode, 0 single-select mode
  input wire logic req_i,                      // Access request
  output logic ready_o,                        // Idle, request accepted
  input wire logic write_i,                    // 1 write, 0 read
  input wire logic [QHBP_CHAN_W-1:0] chan_i,   // Channel 0..3 = A..D
  input wire logic [QHBP_REG_W-1:0] reg_i,     // Register within channel
  input wire logic [QHBP_DATA_W-1:0] wdata_i,  // Write byte
  output logic done_o,                         // Access finished pulse
  output logic [QHBP_DATA_W-1:0] rdata_o,      // Last byte read
  output logic [QHBP_REG_W-1:0] reg_addr_o,    // Register address pins
  output logic [QHBP_DATA_W-1:0] data_o,       // Data bus drive value
  output logic data_oe_n_o,                    // Data bus enable, low drives
  input wire logic [QHBP_DATA_W-1:0] data_i,   // Data bus level
  output logic read_strobe_n_o,                // Read strobe pin
  output logic write_strobe_n_o,               // Write strobe or direction pin
  output logic chan_a_select_n_o,              // Channel A / device select
  output logic chan_b_select_n_o,              // Channel B select / channel_addr_lo
  output logic chan_c_select_n_o,              // Channel C select / channel_addr_hi
  output logic chan_d_select_n_o               // Channel D select
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    qhbp_state_t st;
    logic [QHBP_PH_W-1:0] cnt;
    logic write;
    logic single;
    logic [QHBP_CHAN_W-1:0] chan;
    logic [QHBP_REG_W-1:0] addr;
    logic [QHBP_DATA_W-1:0] wdata;
    logic [QHBP_DATA_W-1:0] rdata;
    logic done;
    logic rs_n;
    logic ws_n;
    logic oe_n;
    logic [QHBP_NCHAN-1:0] cs_n;
  } qhbp_host_state_t;

  qhbp_host_state_t s;
  qhbp_host_state_t next_s;
  logic tick;

  // One-hot low select for a channel number
  function automatic logic [QHBP_NCHAN-1:0] chan_sel_n(input logic [QHBP_CHAN_W-1:0] c);
    logic [QHBP_NCHAN-1:0] v;
    v = QHBP_ALL_DESEL;
    v[c] = 1'b0;
    return v;
  endfunction

  // Bus tick divider, restarted when a request is taken
  qhbp_tick u_tick (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(ready_o && req_i),
    .tick_o(tick)
  );

  // ****************************************
  // Access sequencer
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.st)
      QHBP_IDLE: begin
        if (req_i) begin
          next_s.st = QHBP_SETUP;
          next_s.cnt = '0;
          next_s.write = write_i;
          next_s.single = (bus_style_i != QHBP_STYLE_STROBE);
          next_s.chan = chan_i;
          next_s.addr = reg_i;
          next_s.wdata = wdata_i;
          next_s.oe_n = ~write_i;
          next_s.rs_n = 1'b1;
          if (bus_style_i == QHBP_STYLE_STROBE) begin
            next_s.ws_n = 1'b1;
            next_s.cs_n = chan_sel_n(chan_i);
          end else begin
            next_s.ws_n = ~write_i;
            next_s.cs_n = {1'b1, chan_i[1], chan_i[0], 1'b1};
          end
        end
      end
      QHBP_SETUP: begin
        if (tick) begin
          if (s.cnt == QHBP_SETUP_TICKS - 2'h1) begin
            next_s.st = QHBP_STROBE;
            next_s.cnt = '0;
            if (s.single) begin
              next_s.cs_n[0] = 1'b0;
            end else if (s.write) begin
              next_s.ws_n = 1'b0;
            end else begin
              next_s.rs_n = 1'b0;
            end
          end else begin
            next_s.cnt = s.cnt + 2'h1;
          end
        end
      end
      QHBP_STROBE: begin
        if (tick) begin
          if (s.cnt == QHBP_STROBE_TICKS - 2'h1) begin
            next_s.st = QHBP_HOLD;
            next_s.cnt = '0;
            if (!s.write) begin
              next_s.rdata = data_i;
            end
            if (s.single) begin
              next_s.cs_n[0] = 1'b1;
            end else begin
              next_s.rs_n = 1'b1;
              next_s.ws_n = 1'b1;
            end
          end else begin
            next_s.cnt = s.cnt + 2'h1;
          end
        end
      end
      QHBP_HOLD: begin
        if (tick) begin
          if (s.cnt == QHBP_HOLD_TICKS - 2'h1) begin
            next_s.st = QHBP_IDLE;
            next_s.cnt = '0;
            next_s.done = 1'b1;
            next_s.oe_n = 1'b1;
            next_s.rs_n = 1'b1;
            next_s.ws_n = 1'b1;
            next_s.cs_n = QHBP_ALL_DESEL;
          end else begin
            next_s.cnt = s.cnt + 2'h1;
          end
        end
      end
      default: begin
        next_s.st = QHBP_IDLE;
      end
    endcase
  end

  // State register, pins idle after reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= QHBP_IDLE;
      s.rs_n <= 1'b1;
      s.ws_n <= 1'b1;
      s.oe_n <= 1'b1;
      s.cs_n <= QHBP_ALL_DESEL;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign ready_o = (s.st == QHBP_IDLE);
  assign done_o = s.done;
  assign rdata_o = s.rdata;
  assign reg_addr_o = s.addr;
  assign data_o = s.wdata;
  assign data_oe_n_o = s.oe_n;
  assign read_strobe_n_o = s.rs_n;
  assign write_strobe_n_o = s.ws_n;
  assign chan_a_select_n_o = s.cs_n[0];
  assign chan_b_select_n_o = s.cs_n[1];
  assign chan_c_select_n_o = s.cs_n[2];
  assign chan_d_select_n_o = s.cs_n[3];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  a_one_select: assert property (!s.single |-> $onehot0(~s.cs_n))
    else $error("more than one channel select low");
  a_sel_matches: assert property (!s.single && s.st != QHBP_IDLE |-> s.cs_n == chan_sel_n(s.chan))
    else $error("select does not match channel");
  a_read_unused: assert property (s.single |-> s.rs_n)
    else $error("read strobe active in single-select mode");
  a_dir_level: assert property (s.single && s.st != QHBP_IDLE |-> s.ws_n == !s.write)
    else $error("direction level wrong");
  a_dev_select: assert property ($fell(s.cs_n[0]) && s.single |-> !s.cs_n[0] [*8] ##1 s.cs_n[0])
    else $error("device select pulse width wrong");
  a_chan_bits: assert property (s.single && s.st != QHBP_IDLE |-> s.cs_n[2:1] == s.chan)
    else $error("channel address bits wrong");
  a_chan_d_idle: assert property (s.single |-> s.cs_n[3])
    else $error("channel D select used in single-select mode");
  a_read_release: assert property (!s.oe_n |-> s.write)
    else $error("data bus driven during read");
  a_read_width: assert property ($fell(s.rs_n) |-> !s.rs_n [*8] ##1 s.rs_n)
    else $error("read strobe width wrong");
  a_read_sample: assert property ($rose(s.rs_n) |-> s.rdata == $past(data_i))
    else $error("read byte not sampled at strobe rise");
  a_write_hold: assert property ($rose(s.ws_n) && !s.single |-> !s.oe_n && $stable(s.wdata)
    && $stable(s.addr) && $stable(s.cs_n) ##4 s.oe_n)
    else $error("write data not held over strobe rise");
  a_write_start: assert property ($fell(s.ws_n) && !s.single |-> s.write && s.st == QHBP_STROBE)
    else $error("write strobe without write access");
  a_addr_stable: assert property (s.st == QHBP_STROBE |-> $stable(s.addr) && $stable(s.cs_n[3:1]))
    else $error("address moved during strobe");

  c_strobe_read: cover property ($rose(s.rs_n) && !s.single);
  c_strobe_write: cover property ($rose(s.ws_n) && !s.single);
  c_single_read: cover property ($rose(s.cs_n[0]) && s.single && !s.write);
  c_single_write: cover property ($rose(s.cs_n[0]) && s.single && s.write);
endmodule

// File: hw/qhbp_pkg.sv
// Constants shared by the quad UART host bus port controller
package qhbp_pkg;
  localparam int QHBP_DATA_W = 8;           // Data bus width
  localparam int QHBP_REG_W = 3;            // Register address lines
  localparam int QHBP_CHAN_W = 2;           // Channel number width
  localparam int QHBP_NCHAN = 4;            // Channels A to D
  localparam int QHBP_DIV_CYCLES = 4;       // Clock cycles per bus tick
  localparam int QHBP_DIV_W = 2;            // Divider counter width
  localparam int QHBP_PH_W = 2;             // Phase tick counter width
  localparam logic [1:0] QHBP_SETUP_TICKS = 2'h1;   // Address/select before strobe
  localparam logic [1:0] QHBP_STROBE_TICKS = 2'h2;  // Strobe low width
  localparam logic [1:0] QHBP_HOLD_TICKS = 2'h1;    // Hold after strobe rises
  localparam logic QHBP_STYLE_STROBE = 1'h1;        // Bus-style pin: strobe mode
  localparam logic [3:0] QHBP_ALL_DESEL = 4'hf;     // No select asserted
  typedef enum logic [1:0] {QHBP_IDLE, QHBP_SETUP, QHBP_STROBE, QHBP_HOLD} qhbp_state_t;
endpackage

// File: hw/qhbp_tick.sv
// Restartable divider giving a one-cycle bus tick enable
`timescale 1ns/10ps
module qhbp_tick
  import qhbp_pkg::*;
(
  input wire logic mclk_i,   // System clock
  input wire logic rst_i,    // Synchronous reset, active high
  input wire logic clear_i,  // Restart the divider
  output logic tick_o        // One-cycle enable pulse
);
  typedef struct packed {
    logic [QHBP_DIV_W-1:0] cnt;
    logic tick;
  } qhbp_tick_state_t;

  qhbp_tick_state_t s;
  qhbp_tick_state_t next_s;

  // Count cycles, pulse on the last one
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (clear_i) begin
      next_s.cnt = '0;
    end else if (s.cnt == QHBP_DIV_W'(QHBP_DIV_CYCLES - 1)) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + QHBP_DIV_W'(1);
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;
endmodule

// File: testbench/qhbp_dev_model.sv
// Behavioural quad UART bus port: registers of four channels, both bus styles
`timescale 1ns/10ps
module qhbp_dev_model
  import qhbp_pkg::*;
(
  input wire logic style_i,       // Bus-style pin
  input wire logic [2:0] addr_i,  // Register address pins
  input wire logic [7:0] bus_i,   // Resolved data bus
  input wire logic rd_n_i,        // Read strobe
  input wire logic wr_n_i,        // Write strobe or direction
  input wire logic a_n_i,         // Channel A or device select
  input wire logic b_n_i,         // Channel B select or channel_addr_lo
  input wire logic c_n_i,         // Channel C select or channel_addr_hi
  input wire logic d_n_i,         // Channel D select
  output logic [7:0] bus_o        // Driven byte, or inverse of it once released
);
  logic [7:0] regs [32];
  logic [7:0] rdv = 8'h00;
  wire [3:0] cs = {d_n_i, c_n_i, b_n_i, a_n_i};
  // Channel decode per bus style
  wire one = style_i ? ($countones(~cs) == 1) : !a_n_i;
  wire [1:0] ch = style_i ? (cs == 4'hd ? 2'h1 : cs == 4'hb ? 2'h2 : cs == 4'h7 ? 2'h3 : 2'h0)
                          : {c_n_i, b_n_i};
  // Access windows; read strobe unused in single-select style
  wire rd_on = one && (style_i ? !rd_n_i : wr_n_i);
  wire wr_on = one && !wr_n_i;
  initial begin
    for (int i = 0; i < 32; i++) regs[i] = 8'h00;
  end
  // Read fetch at window start, byte driven until its end
  always @(posedge rd_on) rdv = regs[{ch, addr_i}];
  assign bus_o = rd_on ? rdv : ~rdv;
  // Write lands at the end of the window
  always @(negedge wr_on) regs[{ch, addr_i}] = bus_i;
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the quad UART host bus port controller
`timescale 1ns/10ps
module tb_top;
  import qhbp_pkg::*;
  logic mclk_i = 0, rst_i = 1, bus_style_i = 1, req_i = 0, write_i = 0;
  logic [1:0] chan_i = 0;
  logic [2:0] reg_i = 0, reg_addr_o;
  logic [7:0] wdata_i = 0, bus_o, rdata_o, data_o;
  logic ready_o, done_o, data_oe_n_o, read_strobe_n_o, write_strobe_n_o;
  logic chan_a_select_n_o, chan_b_select_n_o, chan_c_select_n_o, chan_d_select_n_o;
  wire [7:0] data_i = data_oe_n_o ? bus_o : data_o;
  wire [9:0] pins = {reg_addr_o, read_strobe_n_o, write_strobe_n_o, chan_d_select_n_o,
                     chan_c_select_n_o, chan_b_select_n_o, chan_a_select_n_o, data_oe_n_o};
  int err_total = 0, checked = 0, seed = 93, mem[32];
  qhbp_host qhbp_host_inst(.mclk_i, .rst_i, .bus_style_i, .req_i, .ready_o, .write_i,
    .chan_i, .reg_i, .wdata_i, .done_o, .rdata_o, .reg_addr_o, .data_o, .data_oe_n_o,
    .data_i, .read_strobe_n_o, .write_strobe_n_o, .chan_a_select_n_o, .chan_b_select_n_o,
    .chan_c_select_n_o, .chan_d_select_n_o);
  qhbp_dev_model qhbp_dev_model_inst(.style_i(bus_style_i), .addr_i(reg_addr_o),
    .bus_i(data_i), .rd_n_i(read_strobe_n_o), .wr_n_i(write_strobe_n_o),
    .a_n_i(chan_a_select_n_o), .b_n_i(chan_b_select_n_o), .c_n_i(chan_c_select_n_o),
    .d_n_i(chan_d_select_n_o), .bus_o);
  //**********************************
  // Clock, checks and verdict
  //**********************************
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic chk_pins(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t pins got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One access; pins looked at mid strobe, read result against the bench copy in mem
  task automatic access(input logic m, input logic w, input logic [1:0] c,
                        input logic [2:0] r, input logic [7:0] d);
    int n;
    logic [3:0] sel;
    @(posedge mclk_i);
    bus_style_i <= m;
    req_i <= 1;
    write_i <= w;
    chan_i <= c;
    reg_i <= r;
    wdata_i <= d;
    @(posedge mclk_i);
    req_i <= 0;
    sel = 4'hf;
    sel[c] = 1'b0;
    if (!m) sel = {1'b1, c[1], c[0], 1'b0};
    for (n = 1; n < 40 && done_o !== 1'b1; n++) begin
      @(posedge mclk_i);
      #1;
      if (n == 8) chk_pins(pins, {r, !m | w, !w, sel, !w});
      if (n == 8 && w) chk_byte(data_o, d);
      if (n == 8) chk_byte({7'h00, ready_o}, 8'h00);
    end
    // Done seen after edge 17 of the access, loop count one past it
    chk_byte(8'(n), 8'h12);
    chk_byte({7'h00, ready_o}, 8'h01);
    chk_pins({r, pins[6:0]}, {r, 7'h7f});
    if (w) mem[{c, r}] = d;
    else chk_byte(rdata_o, 8'(mem[{c, r}]));
  endtask
  //**********************************
  // Main sequence and watchdog
  //**********************************
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 0;
    #1;
    chk_pins(pins, 10'h07f);
    chk_byte(rdata_o, 8'h00);
    // Every channel and register, read back in the other style
    for (int i = 0; i < 64; i++) begin
      access(i[5], 1'b1, i[4:3], i[2:0], 8'($random(seed)));
      access(!i[5], 1'b0, i[4:3], i[2:0], 8'h00);
    end
    // Random mix of styles and directions
    repeat (60) access(1'($random(seed)), 1'($random(seed)), 2'($random(seed)),
                       3'($random(seed)), 8'($random(seed)));
    wrap_up();
  end
  initial begin
    #40000;
    err_total++;
    wrap_up();
  end
endmodule
